//--- rya_pkg.sv
// Constants for the periodic and year alarm control block
package rya_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [3:0] RYA_OFF_CTRL_TWO = 4'h0;
    localparam logic [3:0] RYA_OFF_CTRL_THREE = 4'h4;
    localparam logic [3:0] RYA_OFF_YEAR_ALARM = 4'h8;
    // ------------------------------------------------------------
    // Field positions of rtc_control_two
    // ------------------------------------------------------------
    localparam int RYA_FLAG_BIT = 7;
    localparam int RYA_SEL_HI = 6;
    localparam int RYA_SEL_LO = 4;
    localparam int RYA_OSC_BIT = 3;
    localparam int RYA_ADJUST_BIT = 2;
    localparam int RYA_DRST_BIT = 1;
    localparam int RYA_START_BIT = 0;
    // Field position of rtc_control_three
    localparam int RYA_YEAR_EN_BIT = 7;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RYA_CTRL_TWO_RST = 8'h09;
    localparam logic [7:0] RYA_CTRL_THREE_RST = 8'h00;
    localparam logic [2:0] RYA_SEL_RST = 3'h0;
    // ------------------------------------------------------------
    // Period select codes
    // ------------------------------------------------------------
    localparam logic [2:0] RYA_SEL_NONE = 3'h0;
    localparam logic [2:0] RYA_SEL_2S = 3'h7;
    // ------------------------------------------------------------
    // Divider chain: oscillator ticks to 256 Hz, to 64 Hz, to 1 Hz
    // ------------------------------------------------------------
    localparam int RYA_PRESC_W = 7;
    localparam int RYA_QUART_W = 2;
    localparam int RYA_C64_W = 6;
    localparam logic [7:0] RYA_SEC_ROUND = 8'h30;
endpackage

//--- rya_ctrl.sv
// Periodic interrupt, divider, start/stop and year alarm control with a Wishbone slave
`timescale 1ns/10ps

module rya_ctrl
    import rya_pkg::*;
(
    input wire logic clk_sys, // System clock, 10 MHz
    input wire logic resetn, // Power-on reset
    input wire logic manual_reset_n, // Manual reset, synchronous level
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write
    input wire logic [3:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic wb_ack_o, // Wishbone acknowledge
    output logic [31:0] wb_dat_o, // Wishbone read data
    input wire logic osc_tick_i, // One pulse per crystal period
    input wire logic [7:0] sec_bcd_i, // Seconds counter, BCD
    input wire logic [15:0] year_counter_i, // Year counter, BCD
    input wire logic other_alarm_match_i, // Other enabled alarm fields all match
    output logic osc_enable_o, // Oscillator run request
    output logic count_enable_o, // Calendar counters may count
    output logic second_tick_o, // One-second advance pulse
    output logic sec_clear_o, // Clear seconds pulse
    output logic minute_advance_o, // Advance minute pulse
    output logic [5:0] sixty_four_hz_counter_o, // Sub-second counter
    output logic periodic_irq_o, // Periodic interrupt request
    output logic alarm_match_o // Alarm flag set request
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic period_hit(input logic [2:0] sel, input logic [6:0] hits);
        return (sel != RYA_SEL_NONE) && hits[sel - 3'h1];
    endfunction

    function automatic logic all_ones(input logic [5:0] v, input int n);
        logic [5:0] m;
        m = ~(6'h3f << n);
        return (v & m) == m;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic flag_q;
    logic [2:0] sel_q;
    logic osc_en_q;
    logic drst_q;
    logic start_q;
    logic year_en_q;
    logic [15:0] year_alarm_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [RYA_PRESC_W-1:0] presc_q;
    logic [RYA_QUART_W-1:0] quart_q;
    logic [RYA_C64_W-1:0] c64_q;
    logic two_q;
    logic sec_tick_q;
    logic sec_clr_q;
    logic min_adv_q;
    logic irq_q;
    logic match_q;

    logic req, wr, wr_two, wr_three, wr_year_lo, wr_year_hi, adjust_wr, drst_wr, chain_clr;
    logic tick, t256, t64, one_hz, phit, year_ok;
    logic [6:0] hits;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = req && wb_we_i;
    // Control two ignores writes while manual reset holds it
    assign wr_two = wr && manual_reset_n && wb_sel_i[0] && wb_adr_i == RYA_OFF_CTRL_TWO;
    assign wr_three = wr && wb_sel_i[0] && wb_adr_i == RYA_OFF_CTRL_THREE;
    assign wr_year_lo = wr && wb_sel_i[0] && wb_adr_i == RYA_OFF_YEAR_ALARM;
    assign wr_year_hi = wr && wb_sel_i[1] && wb_adr_i == RYA_OFF_YEAR_ALARM;
    assign adjust_wr = wr_two && wb_dat_i[RYA_ADJUST_BIT];
    assign drst_wr = wr_two && wb_dat_i[RYA_DRST_BIT];
    assign chain_clr = adjust_wr || drst_wr;

    // ------------------------------------------------------------
    // Divider chain
    // ------------------------------------------------------------
    // Crystal ticks are dropped while the oscillator is halted
    assign tick = osc_tick_i && osc_en_q;
    assign t256 = tick && (&presc_q);
    assign t64 = t256 && (&quart_q);
    assign one_hz = t64 && all_ones(c64_q, 6);
    assign hits[0] = t256;
    assign hits[1] = t64;
    assign hits[2] = t64 && all_ones(c64_q, 2);
    assign hits[3] = t64 && all_ones(c64_q, 4);
    assign hits[4] = t64 && all_ones(c64_q, 5);
    assign hits[5] = one_hz;
    assign hits[6] = one_hz && two_q;
    assign phit = period_hit(sel_q, hits);

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            presc_q <= '0;
            quart_q <= '0;
            c64_q <= '0;
            two_q <= 1'b0;
        end
        else if (chain_clr)
        begin
            presc_q <= '0;
            quart_q <= '0;
            c64_q <= '0;
            two_q <= 1'b0;
        end
        else if (tick)
        begin
            // Runs regardless of start, only the oscillator stops it
            presc_q <= presc_q + 1'b1;
            if (t256)
            begin
                quart_q <= quart_q + 1'b1;
            end
            if (t64)
            begin
                c64_q <= c64_q + 1'b1;
            end
            if (one_hz)
            begin
                two_q <= !two_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Control two
    // ------------------------------------------------------------
    // Only the two resets reset this register; standby has no path in
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            // Flag is undefined after reset; zero chosen
            flag_q <= RYA_CTRL_TWO_RST[RYA_FLAG_BIT];
            sel_q <= RYA_CTRL_TWO_RST[RYA_SEL_HI:RYA_SEL_LO];
            osc_en_q <= RYA_CTRL_TWO_RST[RYA_OSC_BIT];
            drst_q <= RYA_CTRL_TWO_RST[RYA_DRST_BIT];
            start_q <= RYA_CTRL_TWO_RST[RYA_START_BIT];
        end
        else if (!manual_reset_n)
        begin
            flag_q <= RYA_CTRL_TWO_RST[RYA_FLAG_BIT];
            sel_q <= RYA_SEL_RST;
            drst_q <= 1'b0;
        end
        else
        begin
            // A period that elapses during a clearing write still wins
            if (phit)
            begin
                flag_q <= 1'b1;
            end
            else if (wr_two)
            begin
                flag_q <= wb_dat_i[RYA_FLAG_BIT];
            end
            if (wr_two)
            begin
                sel_q <= wb_dat_i[RYA_SEL_HI:RYA_SEL_LO];
                osc_en_q <= wb_dat_i[RYA_OSC_BIT];
                start_q <= wb_dat_i[RYA_START_BIT];
            end
            drst_q <= drst_wr;
        end
    end

    // ------------------------------------------------------------
    // Control three and year alarm value
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            year_en_q <= RYA_CTRL_THREE_RST[RYA_YEAR_EN_BIT];
        end
        else if (wr_three)
        begin
            year_en_q <= wb_dat_i[RYA_YEAR_EN_BIT];
        end
    end

    // No reset at all: contents survive every reset
    always_ff @(posedge clk_sys)
    begin
        if (wr_year_lo)
        begin
            year_alarm_q[7:0] <= wb_dat_i[7:0];
        end
        if (wr_year_hi)
        begin
            year_alarm_q[15:8] <= wb_dat_i[15:8];
        end
    end

    // ------------------------------------------------------------
    // Bus answer, one cycle after the request
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end
        else
        begin
            ack_q <= req;
            if (req)
            begin
                unique case (wb_adr_i)
                    RYA_OFF_CTRL_TWO: rdata_q <= {24'h000000, flag_q, sel_q, osc_en_q, 1'b0, drst_q, start_q};
                    RYA_OFF_CTRL_THREE: rdata_q <= {24'h000000, year_en_q, 7'h00};
                    RYA_OFF_YEAR_ALARM: rdata_q <= {16'h0000, year_alarm_q};
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Counter control pulses
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            sec_tick_q <= 1'b0;
            sec_clr_q <= 1'b0;
            min_adv_q <= 1'b0;
        end
        else
        begin
            sec_tick_q <= one_hz && start_q && !chain_clr;
            sec_clr_q <= adjust_wr;
            min_adv_q <= adjust_wr && sec_bcd_i >= RYA_SEC_ROUND;
        end
    end

    // ------------------------------------------------------------
    // Requests
    // ------------------------------------------------------------
    // Year alarm disabled reads as a match, so undefined contents are harmless
    assign year_ok = !year_en_q || year_counter_i == year_alarm_q;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_q <= 1'b0;
            match_q <= 1'b0;
        end
        else
        begin
            irq_q <= flag_q && sel_q != RYA_SEL_NONE;
            match_q <= other_alarm_match_i && year_ok;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign osc_enable_o = osc_en_q;
    assign count_enable_o = start_q;
    assign second_tick_o = sec_tick_q;
    assign sec_clear_o = sec_clr_q;
    assign minute_advance_o = min_adv_q;
    assign sixty_four_hz_counter_o = c64_q;
    assign periodic_irq_o = irq_q;
    assign alarm_match_o = match_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    irq_level_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ##1 irq_q == ($past(flag_q) && $past(sel_q) != RYA_SEL_NONE))
        else $error("periodic request does not follow flag and select");

    flag_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        phit && manual_reset_n |=> flag_q)
        else $error("elapsed period did not set the flag");

    flag_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        flag_q && !wr_two && manual_reset_n |=> flag_q)
        else $error("flag cleared without a write");

    manual_keep_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !manual_reset_n |=> $stable(osc_en_q) && $stable(start_q) && sel_q == RYA_SEL_RST)
        else $error("manual reset handling of control two wrong");

    drst_self_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        drst_q |=> !drst_q || $past(drst_wr))
        else $error("divider reset bit did not clear itself");

    chain_clr_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        chain_clr |=> presc_q == '0 && c64_q == '0)
        else $error("divider chain not cleared");

    osc_halt_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !osc_en_q && !chain_clr |=> $stable(presc_q) && $stable(c64_q))
        else $error("divider moved while oscillator halted");

    c64_runs_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        t64 && !start_q && !chain_clr |=> c64_q == $past(c64_q) + 6'h01)
        else $error("64 Hz counter stalled by start bit");

    stop_sec_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !start_q |=> !sec_tick_q)
        else $error("second tick while stopped");

    round_up_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        adjust_wr |=> sec_clr_q && (min_adv_q == ($past(sec_bcd_i) >= RYA_SEC_ROUND)))
        else $error("thirty second adjust wrong");

    year_match_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        year_en_q && year_counter_i != year_alarm_q |=> !match_q)
        else $error("alarm match despite year mismatch");

    ctrl3_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        req && !wb_we_i && wb_adr_i == RYA_OFF_CTRL_THREE |=> rdata_q[6:0] == 7'h00 && ack_q)
        else $error("control three low bits not zero");

    adj_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ack_q && $past(wb_adr_i) == RYA_OFF_CTRL_TWO |-> !rdata_q[RYA_ADJUST_BIT])
        else $error("adjust bit read back as one");

    ack_once_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ack_q |=> !ack_q)
        else $error("acknowledge longer than one cycle");

endmodule

//--- rya_ctrl_test.sv
// Self-checking bench for the periodic and year alarm control block
`timescale 1ns/10ps
module rya_ctrl_test;
    import rya_pkg::*;
    logic clk_sys = 1'h0;
    logic resetn = 1'h0;
    logic manual_reset_n = 1'h1;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic osc_tick_i = 1'h0, other_alarm_match_i = 1'h0;
    logic [7:0] sec_bcd_i = 8'h00;
    logic [15:0] year_counter_i = 16'h0000;
    logic wb_ack_o, osc_enable_o, count_enable_o, second_tick_o, sec_clear_o, minute_advance_o;
    logic periodic_irq_o, alarm_match_o;
    logic [31:0] wb_dat_o;
    logic [5:0] sixty_four_hz_counter_o;
    logic [31:0] rd;
    int n_fail = 0;
    int tests_run = 0;
    int n_clr = 0;
    int n_min = 0;
    int n_sec = 0;
    localparam logic [31:0] SECS = 32'h59302900;

    always #50 clk_sys = ~clk_sys;

    rya_ctrl dut (.clk_sys(clk_sys), .resetn(resetn), .manual_reset_n(manual_reset_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .osc_tick_i(osc_tick_i), .sec_bcd_i(sec_bcd_i),
        .year_counter_i(year_counter_i), .other_alarm_match_i(other_alarm_match_i), .osc_enable_o(osc_enable_o),
        .count_enable_o(count_enable_o), .second_tick_o(second_tick_o), .sec_clear_o(sec_clear_o),
        .minute_advance_o(minute_advance_o), .sixty_four_hz_counter_o(sixty_four_hz_counter_o),
        .periodic_irq_o(periodic_irq_o), .alarm_match_o(alarm_match_o));

    // Pulses are counted, so their exact cycle need not be guessed
    always @(posedge clk_sys)
    begin
        if (sec_clear_o === 1'h1)
            n_clr <= n_clr + 1;
        if (minute_advance_o === 1'h1)
            n_min <= n_min + 1;
        if (second_tick_o === 1'h1)
            n_sec <= n_sec + 1;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_cnt(input string what, input int lo, input int hi, input int got);
        tests_run++;
        if (got < lo || got > hi)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [31:0] wd, input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= sel;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
        if (n >= 20)
            check_cnt("ack wait", 0, 19, n);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        wb_cycle(1'h1, a, d, 4'h3);
    endtask

    task automatic rdc(input string what, input logic [3:0] a, input logic [31:0] exp);
        wb_cycle(1'h0, a, 32'h0, 4'hf);
        check_val(what, exp, rd);
    endtask

    task automatic ticks(input int n);
        osc_tick_i <= 1'h1;
        cycles(n);
        osc_tick_i <= 1'h0;
        cycles(2);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdc("control two", RYA_OFF_CTRL_TWO, 32'h09);
        rdc("control three", RYA_OFF_CTRL_THREE, 32'h00);
        check_val("osc enable", 32'h1, osc_enable_o);
        check_val("count enable", 32'h1, count_enable_o);
        $display("test reset done");
    endtask

    task automatic t_regs();
        wr(RYA_OFF_CTRL_THREE, 32'hff);
        rdc("control three", RYA_OFF_CTRL_THREE, 32'h80);
        wb_cycle(1'h1, RYA_OFF_CTRL_THREE, 32'h00, 4'h0);
        rdc("unselected write", RYA_OFF_CTRL_THREE, 32'h80);
        wr(RYA_OFF_YEAR_ALARM, 32'h9999);
        rdc("year alarm", RYA_OFF_YEAR_ALARM, 32'h9999);
        wb_cycle(1'h1, RYA_OFF_YEAR_ALARM, 32'h1200, 4'h2);
        rdc("year alarm high byte", RYA_OFF_YEAR_ALARM, 32'h1299);
        wr(4'hc, 32'hffffffff);
        rdc("unmapped", 4'hc, 32'h0);
        wr(RYA_OFF_CTRL_THREE, 32'h00);
        $display("test registers done");
    endtask

    task automatic t_adjust();
        int c, m;
        for (int i = 0; i < 4; i++)
        begin
            sec_bcd_i <= SECS[8*i +: 8];
            ticks(1100);
            c = n_clr;
            m = n_min;
            wr(RYA_OFF_CTRL_TWO, 32'h0d);
            cycles(3);
            check_cnt("seconds clear", c + 1, c + 1, n_clr);
            check_cnt("minute advance", m + (i >= 2), m + (i >= 2), n_min);
            check_val("sub second count", 32'h0, {26'h0, sixty_four_hz_counter_o});
            rdc("adjust reads zero", RYA_OFF_CTRL_TWO, 32'h09);
        end
        ticks(1100);
        wr(RYA_OFF_CTRL_TWO, 32'h0b);
        cycles(1);
        check_val("divider reset", 32'h0, {26'h0, sixty_four_hz_counter_o});
        rdc("divider bit clears", RYA_OFF_CTRL_TWO, 32'h09);
        $display("test adjust done");
    endtask

    task automatic t_start();
        wr(RYA_OFF_CTRL_TWO, 32'h0a);
        check_val("count enable", 32'h0, count_enable_o);
        ticks(1100);
        check_val("sub second runs", 32'h2, {26'h0, sixty_four_hz_counter_o});
        wr(RYA_OFF_CTRL_TWO, 32'h00);
        check_val("osc enable", 32'h0, osc_enable_o);
        ticks(1100);
        check_val("sub second halted", 32'h2, {26'h0, sixty_four_hz_counter_o});
        wr(RYA_OFF_CTRL_TWO, 32'h09);
        check_val("osc restored", 32'h1, osc_enable_o);
        $display("test start done");
    endtask

    task automatic t_period();
        int n, p, lim, s;
        for (int i = 0; i < 8; i++)
        begin
            p = (i < 5) ? (32 << (2 * i)) : (8192 << (i - 4));
            lim = (i == 0) ? 300 : ((p > 40000) ? 20000 : p + 20);
            wr(RYA_OFF_CTRL_TWO, {24'h0, 1'h0, i[2:0], 4'hb});
            // Let the request of the previous select drop before watching
            cycles(2);
            s = n_sec;
            osc_tick_i <= 1'h1;
            n = 0;
            while (periodic_irq_o !== 1'h1 && n < lim)
            begin
                @(posedge clk_sys);
                n++;
            end
            osc_tick_i <= 1'h0;
            if (i == 0 || p > 40000)
                check_cnt("no early request", lim, lim, n);
            else
            begin
                check_cnt("period", p - 2, p + 4, n);
                if (i == 6)
                    check_cnt("second tick", s + 1, s + 1, n_sec);
                rdc("flag set", RYA_OFF_CTRL_TWO, {24'h0, 1'h1, i[2:0], 4'h9});
                wr(RYA_OFF_CTRL_TWO, {24'h0, 1'h0, i[2:0], 4'h9});
                cycles(2);
                check_val("request cleared", 32'h0, periodic_irq_o);
                wr(RYA_OFF_CTRL_TWO, {24'h0, 1'h1, i[2:0], 4'h9});
                cycles(2);
                check_val("request by write", 32'h1, periodic_irq_o);
            end
        end
        wr(RYA_OFF_CTRL_TWO, 32'h89);
        cycles(2);
        check_val("no select no request", 32'h0, periodic_irq_o);
        wr(RYA_OFF_CTRL_TWO, 32'h09);
        $display("test period done");
    endtask

    task automatic t_manual();
        wr(RYA_OFF_CTRL_TWO, 32'hb8);
        wr(RYA_OFF_CTRL_THREE, 32'h80);
        wr(RYA_OFF_YEAR_ALARM, 32'h2024);
        manual_reset_n <= 1'h0;
        cycles(3);
        manual_reset_n <= 1'h1;
        cycles(1);
        rdc("control two kept bits", RYA_OFF_CTRL_TWO, 32'h08);
        rdc("control three kept", RYA_OFF_CTRL_THREE, 32'h80);
        rdc("year alarm kept", RYA_OFF_YEAR_ALARM, 32'h2024);
        wr(RYA_OFF_CTRL_TWO, 32'h09);
        $display("test manual reset done");
    endtask

    task automatic t_alarm();
        other_alarm_match_i <= 1'h1;
        year_counter_i <= 16'h2025;
        wr(RYA_OFF_CTRL_THREE, 32'h00);
        cycles(2);
        check_val("year ignored", 32'h1, alarm_match_o);
        wr(RYA_OFF_CTRL_THREE, 32'h80);
        cycles(2);
        check_val("year differs", 32'h0, alarm_match_o);
        year_counter_i <= 16'h2024;
        cycles(2);
        check_val("year equal", 32'h1, alarm_match_o);
        cycles(4);
        check_val("match holds", 32'h1, alarm_match_o);
        year_counter_i <= 16'h2124;
        cycles(2);
        check_val("hundreds differ", 32'h0, alarm_match_o);
        year_counter_i <= 16'h2024;
        other_alarm_match_i <= 1'h0;
        cycles(2);
        check_val("other fields differ", 32'h0, alarm_match_o);
        wr(RYA_OFF_CTRL_THREE, 32'h00);
        $display("test alarm done");
    endtask

    // ------------------------------------------------------------
    // Sequence and verdict
    // ------------------------------------------------------------
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'h1;
        t_reset();
        t_regs();
        t_adjust();
        t_start();
        t_period();
        t_manual();
        t_alarm();
        final_report();
    end

    // Whole run needs about 89k cycles; a hang stops near 98k
    initial
    begin
        #9800000;
        n_fail++;
        final_report();
    end
endmodule
